// >>> hw/wdc_parser.sv
// Watchdog configuration command parser: decodes ASCII frames, keeps settings
// How it works
// R1 - Set timeout command stores four digits, acknowledges
// R2 - Get timeout returns stored four digits
// R3 - Set slot mask stores two hex characters
// R4 - Get slot mask returns two hex characters
// R5 - Set channel mask stores four hex characters
// R6 - Get channel mask returns that slot's mask
// R7 - Every frame ends with carriage return
// R8 - Only frames with own address are acted on
// R9 - Malformed or foreign frames get no reply
// R10 - Mask bit n enables slot or channel n
`timescale 1ns/10ps
`include "wdc_cfg.svh"
`default_nettype none

module wdc_parser
   import wdc_pkg::*;
(
   // Clock and reset
   input  wire logic              ref_clk,
   input  wire logic              reset,
   // Own network address
   input  wire logic [7:0]        dev_addr,
   // Command bytes in
   input  wire logic              rx_valid,
   input  wire logic [7:0]        rx_data,
   // Reply bytes out
   input  wire logic              tx_ready,
   output logic                   tx_valid,
   output logic [7:0]             tx_data,
   // Stored settings
   output logic [15:0]            timeout_bcd,
   output logic [7:0]             slot_enable_mask,
   output logic [7:0][15:0]       chan_enable_mask
);

   // ************************************************************
   // Receive buffer
   // ************************************************************
   logic [`WDC_RX_DEPTH-1:0][7:0] buf_ff, nxt_buf;   // Frame so far
   logic [3:0]                    len_ff, nxt_len;   // Bytes held
   logic                          act_ff, nxt_act;   // Inside a frame
   logic                          eval;              // Terminator seen

   assign eval = rx_valid && act_ff && (rx_data == `WDC_CHAR_CR); // R7

   // A start character always restarts, so a broken frame cannot wedge us
   always_comb begin
      nxt_buf = buf_ff;
      nxt_len = len_ff;
      nxt_act = act_ff;
      if (rx_valid) begin
         if (rx_data == `WDC_CHAR_START) begin
            nxt_buf[0] = rx_data;
            nxt_len    = 4'h1;
            nxt_act    = 1'b1;
         end else if (act_ff) begin
            // Terminator or overlong frame closes it
            if (rx_data == `WDC_CHAR_CR || len_ff == 4'(`WDC_RX_DEPTH)) begin // R7
               nxt_act = 1'b0;
            end else begin
               nxt_buf[len_ff] = rx_data;
               nxt_len         = len_ff + 4'h1;
            end
         end
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         buf_ff <= '0;
         len_ff <= 4'h0;
         act_ff <= 1'b0;
      end else begin
         buf_ff <= nxt_buf;
         len_ff <= nxt_len;
         act_ff <= nxt_act;
      end
   end

   // ************************************************************
   // Frame decode
   // ************************************************************
   logic        addr_ok;   // Address field names us
   wdc_cmd_type cmd;       // Recognised command
   logic        fail;      // Valid frame, invalid operation
   logic [3:0]  slot_val;  // Slot digit value
   logic [2:0]  slot_idx;  // Slot index into masks
   logic [15:0] new_val;   // Value carried by a set command

   // Anything not matching exactly stays CMD_NONE and is answered with silence
   always_comb begin
      cmd      = CMD_NONE;
      addr_ok  = hex_ok(buf_ff[1]) && hex_ok(buf_ff[2]) &&
                 ({hex_val(buf_ff[1]), hex_val(buf_ff[2])} == dev_addr); // R8
      slot_val = hex_val(buf_ff[5]);
      slot_idx = slot_val[2:0];
      fail     = 1'b0;
      new_val  = 16'h0000;
      if (eval && addr_ok && len_ff >= 4'h4 && buf_ff[3] == `WDC_CHAR_X) begin // R8 R9
         if (len_ff == 4'h8 && dec_ok(buf_ff[4]) && dec_ok(buf_ff[5]) &&
             dec_ok(buf_ff[6]) && dec_ok(buf_ff[7])) begin
            cmd     = CMD_SET_TMO; // R1
            new_val = {hex_val(buf_ff[4]), hex_val(buf_ff[5]),
                       hex_val(buf_ff[6]), hex_val(buf_ff[7])};
         end else if (len_ff == 4'h5 && buf_ff[4] == `WDC_CHAR_R) begin
            cmd = CMD_GET_TMO; // R2
         end else if (len_ff == 4'h8 && buf_ff[4] == `WDC_CHAR_E &&
                      buf_ff[5] == `WDC_CHAR_W && hex_ok(buf_ff[6]) &&
                      hex_ok(buf_ff[7])) begin
            cmd     = CMD_SET_SLOT; // R3
            new_val = {8'h00, hex_val(buf_ff[6]), hex_val(buf_ff[7])};
         end else if (len_ff == 4'h6 && buf_ff[4] == `WDC_CHAR_E &&
                      buf_ff[5] == `WDC_CHAR_R) begin
            cmd = CMD_GET_SLOT; // R4
         end else if (len_ff == 4'h6 && buf_ff[4] == `WDC_CHAR_S &&
                      dec_ok(buf_ff[5])) begin
            cmd = CMD_GET_CHAN; // R6
         end else if (len_ff == 4'hb && buf_ff[4] == `WDC_CHAR_S &&
                      dec_ok(buf_ff[5]) && buf_ff[6] == `WDC_CHAR_D &&
                      hex_ok(buf_ff[7]) && hex_ok(buf_ff[8]) &&
                      hex_ok(buf_ff[9]) && hex_ok(buf_ff[10])) begin
            cmd     = CMD_SET_CHAN; // R5
            new_val = {hex_val(buf_ff[7]), hex_val(buf_ff[8]),
                       hex_val(buf_ff[9]), hex_val(buf_ff[10])};
         end
         // A slot digit past the last slot is refused with a fail frame
         if ((cmd == CMD_GET_CHAN || cmd == CMD_SET_CHAN) &&
             slot_val >= 4'(`WDC_SLOT_NUM)) begin
            fail = 1'b1;
         end
      end
   end

   // ************************************************************
   // Stored settings
   // ************************************************************
   logic [15:0]      tmo_ff, nxt_tmo;     // Timeout, four BCD digits
   logic [7:0]       slot_ff, nxt_slot;   // Bit n enables slot n
   logic [7:0][15:0] chan_ff, nxt_chan;   // Per slot channel enables

   assign timeout_bcd      = tmo_ff;
   assign slot_enable_mask = slot_ff;  // R10
   assign chan_enable_mask = chan_ff;  // R10

   // Settings change even if the reply has to be dropped
   always_comb begin
      nxt_tmo  = tmo_ff;
      nxt_slot = slot_ff;
      nxt_chan = chan_ff;
      if (cmd == CMD_SET_TMO) begin
         nxt_tmo = new_val; // R1
      end
      if (cmd == CMD_SET_SLOT) begin
         nxt_slot = new_val[7:0]; // R3 R10
      end
      if (cmd == CMD_SET_CHAN && !fail) begin
         nxt_chan[slot_idx] = new_val; // R5 R10
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         tmo_ff  <= `WDC_TMO_RST;
         slot_ff <= `WDC_SLOT_RST;
         chan_ff <= {`WDC_SLOT_NUM{`WDC_CHAN_RST}};
      end else begin
         tmo_ff  <= nxt_tmo;
         slot_ff <= nxt_slot;
         chan_ff <= nxt_chan;
      end
   end

   // ************************************************************
   // Reply assembly
   // ************************************************************
   logic [`WDC_TX_DEPTH-1:0][7:0] rsp;       // Reply bytes
   logic [3:0]                    rsp_len;   // Reply length
   logic                          load;      // Start a reply

   // A reply that arrives while one is still going out is dropped
   assign load = (cmd != CMD_NONE) && !tx_valid; // R9

   always_comb begin
      rsp     = '0;
      rsp[0]  = fail ? `WDC_CHAR_FAIL : `WDC_CHAR_OK;
      rsp[1]  = to_hex(dev_addr[7:4]);
      rsp[2]  = to_hex(dev_addr[3:0]);
      rsp[3]  = `WDC_CHAR_CR; // R7
      rsp_len = 4'h4;
      if (!fail) begin
         unique case (cmd)
            CMD_GET_TMO: begin // R2
               rsp[3]  = to_hex(tmo_ff[15:12]);
               rsp[4]  = to_hex(tmo_ff[11:8]);
               rsp[5]  = to_hex(tmo_ff[7:4]);
               rsp[6]  = to_hex(tmo_ff[3:0]);
               rsp[7]  = `WDC_CHAR_CR;
               rsp_len = 4'h8;
            end
            CMD_GET_SLOT: begin // R4
               rsp[3]  = to_hex(slot_ff[7:4]);
               rsp[4]  = to_hex(slot_ff[3:0]);
               rsp[5]  = `WDC_CHAR_CR;
               rsp_len = 4'h6;
            end
            CMD_GET_CHAN: begin // R6
               rsp[3]  = to_hex(chan_ff[slot_idx][15:12]);
               rsp[4]  = to_hex(chan_ff[slot_idx][11:8]);
               rsp[5]  = to_hex(chan_ff[slot_idx][7:4]);
               rsp[6]  = to_hex(chan_ff[slot_idx][3:0]);
               rsp[7]  = `WDC_CHAR_CR;
               rsp_len = 4'h8;
            end
            CMD_NONE, CMD_SET_TMO, CMD_SET_SLOT, CMD_SET_CHAN: begin
               rsp_len = 4'h4;
            end
         endcase
      end
   end

   // Serializer
   wdc_tx u_tx (
      .ref_clk  (ref_clk),
      .reset    (reset),
      .load     (load),
      .bytes    (rsp),
      .count    (rsp_len),
      .tx_ready (tx_ready),
      .tx_valid (tx_valid),
      .tx_data  (tx_data)
   );

   // ************************************************************
   // Checks
   // ************************************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);

   sequence s_reply_ok;
      tx_valid && tx_data == `WDC_CHAR_OK;
   endsequence

   sequence s_last_byte;
      tx_valid && tx_ready && tx_data == `WDC_CHAR_CR;
   endsequence

   property p_set_tmo;
      cmd == CMD_SET_TMO |=> timeout_bcd == $past(new_val);
   endproperty
   a_set_tmo: assert property (p_set_tmo) else $error("timeout not stored"); // R1

   property p_get_tmo;
      // Eight reply bytes need at least eight cycles on offer
      cmd == CMD_GET_TMO && load |=> s_reply_ok ##0 tx_valid [*8];
   endproperty
   a_get_tmo: assert property (p_get_tmo) else $error("timeout reply wrong"); // R2

   property p_set_slot;
      cmd == CMD_SET_SLOT |=> slot_enable_mask == $past(new_val[7:0]);
   endproperty
   a_set_slot: assert property (p_set_slot) else $error("slot mask not stored"); // R3

   property p_get_slot;
      cmd == CMD_GET_SLOT && load |=> s_reply_ok;
   endproperty
   a_get_slot: assert property (p_get_slot) else $error("slot reply missing"); // R4

   property p_set_chan;
      cmd == CMD_SET_CHAN && !fail |=> chan_enable_mask[$past(slot_idx)] == $past(new_val);
   endproperty
   a_set_chan: assert property (p_set_chan) else $error("channel mask not stored"); // R5

   property p_bad_slot;
      fail && load |=> tx_valid && tx_data == `WDC_CHAR_FAIL && $stable(chan_enable_mask);
   endproperty
   a_bad_slot: assert property (p_bad_slot) else $error("bad slot not refused"); // R6

   property p_cr_end;
      s_last_byte |=> !tx_valid;
   endproperty
   a_cr_end: assert property (p_cr_end) else $error("frame ran past terminator"); // R7

   property p_foreign;
      eval && !addr_ok |=> !$rose(tx_valid) && $stable(timeout_bcd) && $stable(slot_enable_mask);
   endproperty
   a_foreign: assert property (p_foreign) else $error("foreign frame acted on"); // R8

   property p_silent;
      eval && cmd == CMD_NONE |=> !$rose(tx_valid) && $stable(chan_enable_mask);
   endproperty
   a_silent: assert property (p_silent) else $error("bad frame answered"); // R9

endmodule
`default_nettype wire

// >>> hw/wdc_cfg.svh
// Constants for the watchdog configuration command parser
`ifndef WDC_CFG_SVH
`define WDC_CFG_SVH

// ************************************************************
// Frame characters
// ************************************************************
`define WDC_CHAR_START  8'h24
`define WDC_CHAR_X      8'h58
`define WDC_CHAR_R      8'h52
`define WDC_CHAR_E      8'h45
`define WDC_CHAR_W      8'h57
`define WDC_CHAR_S      8'h53
`define WDC_CHAR_D      8'h44
`define WDC_CHAR_CR     8'h0d
`define WDC_CHAR_OK     8'h21
`define WDC_CHAR_FAIL   8'h3f

// ************************************************************
// Sizes and reset values
// ************************************************************
`define WDC_RX_DEPTH    12
`define WDC_TX_DEPTH    8
`define WDC_SLOT_NUM    8
`define WDC_TMO_RST     16'h0000
`define WDC_SLOT_RST    8'h00
`define WDC_CHAN_RST    16'h0000

`endif

// >>> hw/wdc_pkg.sv
// Types and character helpers for the watchdog configuration parser
package wdc_pkg;

   // ************************************************************
   // Command kinds
   // ************************************************************
   typedef enum logic [2:0] {
      CMD_NONE,
      CMD_SET_TMO,
      CMD_GET_TMO,
      CMD_SET_SLOT,
      CMD_GET_SLOT,
      CMD_SET_CHAN,
      CMD_GET_CHAN
   } wdc_cmd_type;

   // ************************************************************
   // Character helpers
   // ************************************************************
   // True for 0-9, A-F, a-f
   function automatic logic hex_ok(input logic [7:0] c);
      return (c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h46) ||
             (c >= 8'h61 && c <= 8'h66);
   endfunction

   // True for 0-9 only
   function automatic logic dec_ok(input logic [7:0] c);
      return (c >= 8'h30 && c <= 8'h39);
   endfunction

   // Nibble value of a hex character
   function automatic logic [3:0] hex_val(input logic [7:0] c);
      logic [7:0] v;
      if (c <= 8'h39) begin
         v = c - 8'h30;
      end else if (c <= 8'h46) begin
         v = c - 8'h37;
      end else begin
         v = c - 8'h57;
      end
      return v[3:0];
   endfunction

   // Upper-case hex character of a nibble
   function automatic logic [7:0] to_hex(input logic [3:0] n);
      return (n < 4'ha) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
   endfunction

endpackage

// >>> hw/wdc_tx.sv
// Reply serializer: holds one reply frame and hands it out byte by byte
`timescale 1ns/10ps
`include "wdc_cfg.svh"
`default_nettype none

module wdc_tx
   import wdc_pkg::*;
(
   // Clock and reset
   input  wire logic                             ref_clk,
   input  wire logic                             reset,
   // Frame load
   input  wire logic                             load,
   input  wire logic [`WDC_TX_DEPTH-1:0][7:0]    bytes,
   input  wire logic [3:0]                       count,
   // Byte stream out
   input  wire logic                             tx_ready,
   output logic                                  tx_valid,
   output logic [7:0]                            tx_data
);

   // ************************************************************
   // State
   // ************************************************************
   logic [`WDC_TX_DEPTH-1:0][7:0] mem_ff, nxt_mem;     // Frame bytes
   logic [3:0]                    idx_ff, nxt_idx;     // Next byte index
   logic [3:0]                    cnt_ff, nxt_cnt;     // Frame length
   logic                          vld_ff, nxt_vld;     // Byte on offer
   logic [7:0]                    dat_ff, nxt_dat;     // Byte on offer

   assign tx_valid = vld_ff;
   assign tx_data  = dat_ff;

   // Load when idle, advance on each accepted byte
   always_comb begin
      nxt_mem = mem_ff;
      nxt_idx = idx_ff;
      nxt_cnt = cnt_ff;
      nxt_vld = vld_ff;
      nxt_dat = dat_ff;
      if (!vld_ff) begin
         // Idle: a load takes the first byte at once
         if (load) begin
            nxt_mem = bytes;
            nxt_cnt = count;
            nxt_idx = 4'h1;
            nxt_vld = 1'b1;
            nxt_dat = bytes[0];
         end
      end else if (tx_ready) begin
         // Last byte gone ends the frame
         if (idx_ff == cnt_ff) begin
            nxt_vld = 1'b0;
         end else begin
            nxt_dat = mem_ff[idx_ff[2:0]];
            nxt_idx = idx_ff + 4'h1;
         end
      end
   end

   // Registers only
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         mem_ff <= '0;
         idx_ff <= 4'h0;
         cnt_ff <= 4'h0;
         vld_ff <= 1'b0;
         dat_ff <= 8'h00;
      end else begin
         mem_ff <= nxt_mem;
         idx_ff <= nxt_idx;
         cnt_ff <= nxt_cnt;
         vld_ff <= nxt_vld;
         dat_ff <= nxt_dat;
      end
   end

endmodule
`default_nettype wire

// >>> tb/wdc_host.sv
// Host model: sends command frames and gathers reply bytes
`timescale 1ns/10ps
`default_nettype none

module wdc_host (
   // Clock
   input  wire logic        ref_clk,
   // Command bytes to the parser
   output logic             rx_valid,
   output logic [7:0]       rx_data,
   // Reply bytes from the parser
   output logic             tx_ready,
   input  wire logic        tx_valid,
   input  wire logic [7:0]  tx_data
);
   logic [127:0] reply;   // Reply bytes, newest in the low byte
   logic         slow;    // Stall every other cycle when set

   // ************************************************************
   // Reply sink
   // ************************************************************
   initial begin
      rx_valid = 1'b0;
      rx_data  = 8'h00;
      tx_ready = 1'b0;
      reply    = '0;
      slow     = 1'b0;
   end

   // Gather reply bytes; a start byte clears them; a slow sink toggles ready
   always @(posedge ref_clk) begin
      if (tx_valid && tx_ready) begin
         reply <= {reply[119:0], tx_data};
      end else if (rx_valid && rx_data == 8'h24) begin
         // Cleared here only, so the gatherer is the single writer
         reply <= '0;
      end
      tx_ready <= slow ? ~tx_ready : 1'b1;
   end

   // ************************************************************
   // Frame sender
   // ************************************************************
   // One byte per cycle, frame text then the terminator
   task automatic send(input string s);
      @(posedge ref_clk);
      for (int i = 0; i < s.len(); i++) begin
         rx_valid <= 1'b1;
         rx_data  <= s[i];
         @(posedge ref_clk);
      end
      rx_valid <= 1'b1;
      rx_data  <= 8'h0d;
      @(posedge ref_clk);
      // Idle bus shows the inverse, never a stale byte
      rx_valid <= 1'b0;
      rx_data  <= ~rx_data;
   endtask
endmodule

`default_nettype wire

// >>> tb/tb.sv
// Self-checking testbench for the command parser
`timescale 1ns/10ps
`default_nettype none

module tb;
   // ************************************************************
   // Signals
   // ************************************************************
   logic             ref_clk;      // 100 MHz clock
   logic             reset;        // Async reset, active high
   logic [7:0]       dev_addr;     // Own address
   logic             rx_valid;     // Command byte strobe
   logic [7:0]       rx_data;      // Command byte
   logic             tx_ready;     // Sink ready
   logic             tx_valid;     // Reply byte on offer
   logic [7:0]       tx_data;      // Reply byte
   logic [15:0]      timeout_bcd;  // Stored timeout
   logic [7:0]       slot_mask;    // Stored slot mask
   logic [7:0][15:0] chan_mask;    // Stored channel masks
   int               failures;     // Mismatch count
   int               cmp_count;    // Comparison count

   initial ref_clk = 1'b0;
   always #5 ref_clk = ~ref_clk;

   // ************************************************************
   // Instances
   // ************************************************************
   wdc_parser u_dut (
      .ref_clk(ref_clk), .reset(reset), .dev_addr(dev_addr),
      .rx_valid(rx_valid), .rx_data(rx_data), .tx_ready(tx_ready),
      .tx_valid(tx_valid), .tx_data(tx_data), .timeout_bcd(timeout_bcd),
      .slot_enable_mask(slot_mask), .chan_enable_mask(chan_mask));

   wdc_host u_host (
      .ref_clk(ref_clk), .rx_valid(rx_valid), .rx_data(rx_data),
      .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_data(tx_data));

   // ************************************************************
   // Shared tasks
   // ************************************************************
   // Verdict and end of run
   task automatic close_out;
      $display("Compares %0d, mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // Compare one value, count and report
   task automatic check(input logic [127:0] seen, input logic [127:0] exp, input string what);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   // Upper-case hex character, worked out here
   function automatic logic [7:0] hx(input logic [3:0] n);
      return (n < 4'ha) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
   endfunction

   // Send a frame, wait until the reply stream is idle, compare it
   task automatic xchg(input string cmd, input logic [127:0] exp);
      int n;
      u_host.send(cmd);
      n = 0;
      // At least four cycles, so a late first byte is still caught
      do begin
         @(posedge ref_clk);
         #1;
         n++;
      end while ((tx_valid !== 1'b0 || n < 4) && n < 80);
      if (n >= 80) begin
         failures++;
         $display("Error at %0t: reply never ended", $time);
         close_out();
      end else begin
         check(u_host.reply, exp, cmd);
      end
   endtask

   // ************************************************************
   // Scenarios
   // ************************************************************
   // Timeout set, read back, and a restart in mid-frame
   task automatic t_timeout;
      xchg("$01XR", {"!010000", 8'h0d});
      xchg("$01X1234", {"!01", 8'h0d});
      check(timeout_bcd, 16'h1234, "timeout");
      xchg("$01XR", {"!011234", 8'h0d});
      xchg("$01X99$01XR", {"!011234", 8'h0d});
   endtask

   // Slot mask in lower case, read back in upper case
   task automatic t_slot;
      xchg("$01XER", {"!0100", 8'h0d});
      xchg("$01XEWa5", {"!01", 8'h0d});
      check(slot_mask, 8'ha5, "slot mask");
      xchg("$01XER", {"!01A5", 8'h0d});
   endtask

   // Every slot gets its own channel mask; one read with a slow sink
   task automatic t_chan;
      logic [15:0] m;
      for (int i = 0; i < 8; i++) begin
         m = 16'h0f3c ^ 16'(16'h1357 * i);
         xchg($sformatf("$01XS%0dD%04h", i, m), {"!01", 8'h0d});
         check(chan_mask[i], m, "chan mask");
      end
      // Later writes must leave earlier slots alone
      check(chan_mask[0], 16'h0f3c, "slot 0 kept");
      m = 16'h0f3c ^ 16'(16'h1357 * 3);
      u_host.slow = 1'b1;
      xchg("$01XS3", {"!01", hx(m[15:12]), hx(m[11:8]), hx(m[7:4]), hx(m[3:0]), 8'h0d});
      u_host.slow = 1'b0;
   endtask

   // Failures, silences and foreign addresses change nothing
   task automatic t_refuse;
      xchg("$01XS8D1234", {"?01", 8'h0d});
      xchg("$01XS9", {"?01", 8'h0d});
      xchg("$02X5555", 128'h0);
      xchg("$01X12a4", 128'h0);
      xchg("$01XEWg1", 128'h0);
      xchg("$0gXR", 128'h0);
      xchg("$01X123456789012", 128'h0);
      check(timeout_bcd, 16'h1234, "timeout kept");
      check(slot_mask, 8'ha5, "slot mask kept");
   endtask

   // Top of the address range, lower case accepted, a near address refused
   task automatic t_addr;
      @(posedge ref_clk);
      dev_addr <= 8'hff;
      xchg("$ffXR", {"!FF1234", 8'h0d});
      xchg("$FeXR", 128'h0);
      xchg("$01XR", 128'h0);
      @(posedge ref_clk);
      dev_addr <= 8'h01;
   endtask

   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      failures  = 0;
      cmp_count = 0;
      reset     = 1'b1;
      dev_addr  = 8'h01;
      repeat (8) @(posedge ref_clk);
      reset <= 1'b0;
      t_timeout();
      t_slot();
      t_chan();
      t_refuse();
      t_addr();
      close_out();
   end
endmodule

`default_nettype wire
